//--- core/pcs_core.sv
// Program counter, return stack and indirect addressing of the core
`timescale 1ns/1ps
`default_nettype none
module pcs_core (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Instruction decoder
  input  wire logic        step,
  input  wire logic        jump,
  input  wire logic        call,
  input  wire logic [10:0] target,
  input  wire logic        int_vector,
  input  wire logic [12:0] vector_addr,
  input  wire logic        ret,
  input  wire logic        ret_literal,
  input  wire logic        ret_interrupt,
  input  wire logic        pc_low_add,
  input  wire logic [7:0]  pc_low_offset,
  // Data path addressing
  input  wire logic        data_req,
  input  wire logic        data_we,
  input  wire logic [8:0]  data_addr,
  input  wire logic [7:0]  data_wdata,
  input  wire logic        indirect_bank_bit,
  input  wire logic [7:0]  mem_rdata,
  output logic      [8:0]  mem_addr,
  output logic             mem_we,
  output logic      [7:0]  mem_wdata,
  output logic      [7:0]  data_rdata,
  output logic      [12:0] pc
);
  logic [12:0] pc_reg;
  logic [12:0] pc_next;
  logic [7:0]  pc_high_latch_reg;
  logic [7:0]  indirect_pointer_reg;
  logic [7:0]  rdata_reg;
  logic [12:0] stack_top;
  logic        do_push;
  logic        do_pop;
  logic        low_wr;
  logic [8:0]  eff_addr;
  logic        ind_access;
  logic        self_ind;
  logic [12:0] push_val;

  // Event decode: a pop and push never coincide from a sane decoder
  assign do_push = call | int_vector;
  assign do_pop  = ret | ret_literal | ret_interrupt;
  assign low_wr  = reg_wr && reg_addr == pcs_pkg::ADDR_PC_LOW;
  // Call saves the return address; vectoring saves the interrupted PC
  assign push_val = call ? pc_reg + 13'h0001 : pc_reg;

  pcs_stack u_stack (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .push     (do_push),
    .pop      (do_pop),
    .push_data(push_val),
    .top_data (stack_top)
  );

  // Next PC, highest priority first
  always_comb begin
    pc_next = pc_reg;
    if (do_pop) begin
      pc_next = stack_top;
    end else if (int_vector) begin
      pc_next = vector_addr;
    end else if (call || jump) begin
      pc_next = {pc_high_latch_reg[4:pcs_pkg::LATCH_PAGE_LSB],
                 target};
    end else if (low_wr) begin
      pc_next = {pc_high_latch_reg[pcs_pkg::HI_W-1:0], reg_wdata};
    end else if (pc_low_add) begin
      // No carry into the upper bits: tables must stay in one block
      pc_next = {pc_high_latch_reg[pcs_pkg::HI_W-1:0],
                 pc_reg[7:0] + pc_low_offset};
    end else if (step) begin
      pc_next = pc_reg + 13'h0001;
    end
  end

  // Program counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= pcs_pkg::PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  assign pc = pc_reg;

  // High latch; only software writes it, stack traffic leaves it alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_high_latch_reg <= pcs_pkg::LATCH_RST;
    end else if (reg_wr && reg_addr == pcs_pkg::ADDR_HI_LATCH) begin
      pc_high_latch_reg <= reg_wdata;
    end
  end

  // Pointer register, reachable by the register port only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      indirect_pointer_reg <= pcs_pkg::POINTER_RST;
    end else if (reg_wr && reg_addr == pcs_pkg::ADDR_POINTER) begin
      indirect_pointer_reg <= reg_wdata;
    end
  end

  // Register read; the stack pointer has no address at all
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        pcs_pkg::ADDR_PC_LOW:   rdata_reg <= pc_reg[7:0];
        pcs_pkg::ADDR_HI_LATCH: rdata_reg <= pc_high_latch_reg;
        pcs_pkg::ADDR_POINTER:  rdata_reg <= indirect_pointer_reg;
        // Upper PC bits are not visible: this slot reads zero
        pcs_pkg::ADDR_PC_HI_RO: rdata_reg <= 8'h00;
        default:                rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // Indirect addressing: port has no storage, pointer picks the cell
  assign eff_addr   = {indirect_bank_bit, indirect_pointer_reg};
  assign ind_access = data_addr[6:0] == pcs_pkg::IND_PORT_ADDR[6:0];
  assign self_ind   = ind_access &&
                      eff_addr[6:0] == pcs_pkg::IND_PORT_ADDR[6:0];

  // Combinational memory side: the RAM itself sits outside this block
  always_comb begin
    mem_addr  = ind_access ? eff_addr : data_addr;
    mem_wdata = data_wdata;
    // A write looping back through the port is dropped
    mem_we    = data_req && data_we && !self_ind;
  end

  // Read data, sampled from the combinational memory and held until the next read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_rdata <= 8'h00;
    end else if (data_req && !data_we) begin
      data_rdata <= self_ind ? pcs_pkg::SELF_READ_VAL
                             : mem_rdata;
    end
  end

  // Helper for the push/latch check
  sequence s_stack_op;
    do_push || do_pop;
  endsequence

  // Vectoring followed at once by the interrupt return
  sequence s_vector_then_return;
    (int_vector && !do_pop) ##1 (ret_interrupt && !do_push);
  endsequence

  // Offset add with nothing of higher priority in the same cycle
  sequence s_plain_add;
    pc_low_add && !do_pop && !do_push && !jump && !low_wr;
  endsequence

  chk_vector_return: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_vector_then_return |=> pc_reg == $past(pc_reg, 2))
    else $error("interrupt return did not restore pc");

  chk_add_no_carry: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    s_plain_add |=> pc_reg[12:8] == $past(pc_high_latch_reg[4:0]))
    else $error("offset add upper bits not from latch");

  // Read data only stands in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");

  chk_reset_pc_zero: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> pc_reg == 13'h0000)
    else $error("pc not zero after reset");

  chk_low_write_load: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (low_wr && !do_pop && !do_push && !jump) |=>
      pc_reg == {$past(pc_high_latch_reg[4:0]), $past(reg_wdata)})
    else $error("low byte write did not load pc");

  chk_goto_page: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (jump && !do_pop && !do_push) |=>
      pc_reg[12:11] == $past(pc_high_latch_reg[4:3]))
    else $error("goto page bits wrong");

  chk_goto_target: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    ((call || jump) && !do_pop && !int_vector) |=>
      pc_reg[10:0] == $past(target))
    else $error("call target bits wrong");

  chk_call_return: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (call && !do_pop) ##1 (ret && !do_push) |=>
      pc_reg == $past(pc_reg, 2) + 13'h0001)
    else $error("return did not restore call site");

  chk_latch_kept: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (s_stack_op and !reg_wr) |=> $stable(pc_high_latch_reg))
    else $error("stack op changed high latch");

  chk_ind_route: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (data_req && ind_access) |->
      mem_addr == {indirect_bank_bit, indirect_pointer_reg})
    else $error("indirect address wrong");

  chk_self_read: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (data_req && !data_we && self_ind) |=> data_rdata == 8'h00)
    else $error("self indirect read not zero");

  chk_self_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (data_req && data_we && self_ind) |-> !mem_we)
    else $error("self indirect write reached memory");
endmodule
`default_nettype wire

//--- core/pcs_pkg.sv
// Package: constants for the program counter, return stack and pointer
package pcs_pkg;
  localparam int unsigned PC_W           = 13;
  localparam int unsigned STACK_DEPTH    = 8;
  localparam int unsigned SP_W           = 3;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned EA_W           = 9;
  localparam int unsigned TARGET_W       = 11;
  localparam int unsigned HI_W           = 5;
  // Register offsets on the plain register port
  localparam logic [2:0]  ADDR_PC_LOW    = 3'h0;
  localparam logic [2:0]  ADDR_HI_LATCH  = 3'h1;
  localparam logic [2:0]  ADDR_POINTER   = 3'h2;
  localparam logic [2:0]  ADDR_PC_HI_RO  = 3'h3;
  // Field positions
  localparam int unsigned LATCH_PAGE_LSB = 3;
  localparam int unsigned BANK_BIT_POS   = 7;
  // Reset values
  localparam logic [12:0] PC_RST         = 13'h0000;
  localparam logic [7:0]  LATCH_RST      = 8'h00;
  localparam logic [7:0]  POINTER_RST    = 8'h00;
  localparam logic [2:0]  SP_RST         = 3'h0;
  localparam logic [12:0] STACK_RST      = 13'h0000;
  // Data address of the virtual indirect access port
  localparam logic [8:0]  IND_PORT_ADDR  = 9'h000;
  localparam logic [7:0]  SELF_READ_VAL  = 8'h00;
  // Stack operations from the decoder
  typedef enum logic [2:0] {
    PCS_OP_NONE = 3'b001,
    PCS_OP_PUSH = 3'b010,
    PCS_OP_POP  = 3'b100
  } pcs_op_t;
endpackage

//--- core/pcs_stack.sv
// Eight-entry circular return stack with hidden pointer
`timescale 1ns/1ps
`default_nettype none
module pcs_stack (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [12:0] push_data,
  output logic      [12:0] top_data
);
  logic [12:0] entry_reg [pcs_pkg::STACK_DEPTH];
  logic [2:0]  sp_reg;
  logic [2:0]  sp_next;
  logic [2:0]  top_idx;

  // Pointer wraps freely; no overflow or underflow flag exists
  always_comb begin
    sp_next = sp_reg;
    if (push) begin
      sp_next = sp_reg + 3'h1;
    end else if (pop) begin
      sp_next = sp_reg - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sp_reg <= pcs_pkg::SP_RST;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // Entry written at pointer; the ninth push reuses slot of the first
  genvar gi;
  generate
    for (gi = 0; gi < pcs_pkg::STACK_DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          entry_reg[gi] <= pcs_pkg::STACK_RST;
        end else if (push && sp_reg == 3'(gi)) begin
          entry_reg[gi] <= push_data;
        end
      end
    end
  endgenerate

  assign top_idx  = sp_reg - 3'h1;
  assign top_data = entry_reg[top_idx];

  // Push then pop returns the value just pushed
  chk_push_pop_lifo: assert property (@(posedge clk_sys) disable iff (!reset_n)
    push ##1 (pop && !push) |-> top_data == $past(push_data))
    else $error("stack top differs from last push");
endmodule
`default_nettype wire

//--- test/pcs_ram_model.sv
// Data memory model standing behind the core's data port
`timescale 1ns/1ps
`default_nettype none
module pcs_ram_model (
  input  wire logic       clk_sys,
  input  wire logic [8:0] mem_addr,
  input  wire logic       mem_we,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata
);
  logic [7:0] ram [512];
  // Seeded so neighbouring cells differ and a wrong address shows
  initial for (int i = 0; i < 512; i++) ram[i] = i[7:0] ^ 8'hA5;
  // Read is combinational: the core samples it in the request cycle
  assign mem_rdata = ram[mem_addr];
  // Write lands at the edge that takes the request
  always @(posedge clk_sys) begin
    if (mem_we) ram[mem_addr] <= mem_wdata;
  end
endmodule
`default_nettype wire

//--- test/pcs_core_tb.sv
// Self-checking bench for the program counter, stack and pointer block
`timescale 1ns/1ps
`default_nettype none
module pcs_core_tb;
  typedef struct packed {
    logic [3:0]  kind;
    logic [12:0] arg;
    logic [12:0] exp;
  } pcs_row_t;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, step = 1'b0, jump = 1'b0;
  logic        call = 1'b0, int_vector = 1'b0, ret = 1'b0;
  logic        ret_literal = 1'b0, ret_interrupt = 1'b0, pc_low_add = 1'b0;
  logic [10:0] target = 11'h000;
  logic [12:0] vector_addr = 13'h0000, pc;
  logic [7:0]  pc_low_offset = 8'h00, data_wdata = 8'h00;
  logic        data_req = 1'b0, data_we = 1'b0, indirect_bank_bit = 1'b0;
  logic [8:0]  data_addr = 9'h000, mem_addr, seen_addr;
  logic [7:0]  mem_rdata, mem_wdata, data_rdata;
  logic        mem_we, seen_we;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Kinds: 0 step, 1 goto, 2 call, 3 return, 4 literal return,
  // 5 interrupt return, 6 vectoring, 7 low byte write, 8 low byte add
  pcs_row_t    rows [10] = '{
    '{4'h1, 13'h0155, 13'h1955}, '{4'h2, 13'h00AA, 13'h18AA},
    '{4'h0, 13'h0000, 13'h18AB}, '{4'h3, 13'h0000, 13'h1956},
    '{4'h7, 13'h0042, 13'h1842}, '{4'h8, 13'h0010, 13'h1852},
    '{4'h6, 13'h0004, 13'h0004}, '{4'h5, 13'h0000, 13'h1852},
    '{4'h2, 13'h07FF, 13'h1FFF}, '{4'h4, 13'h0000, 13'h1853}};

  pcs_core pcs_core_inst (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .step             (step),
    .jump             (jump),
    .call             (call),
    .target           (target),
    .int_vector       (int_vector),
    .vector_addr      (vector_addr),
    .ret              (ret),
    .ret_literal      (ret_literal),
    .ret_interrupt    (ret_interrupt),
    .pc_low_add       (pc_low_add),
    .pc_low_offset    (pc_low_offset),
    .data_req         (data_req),
    .data_we          (data_we),
    .data_addr        (data_addr),
    .data_wdata       (data_wdata),
    .indirect_bank_bit(indirect_bank_bit),
    .mem_rdata        (mem_rdata),
    .mem_addr         (mem_addr),
    .mem_we           (mem_we),
    .mem_wdata        (mem_wdata),
    .data_rdata       (data_rdata),
    .pc               (pc)
  );
  pcs_ram_model pcs_ram_model_inst (
    .clk_sys  (clk_sys),
    .mem_addr (mem_addr),
    .mem_we   (mem_we),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
  );

  // Clock: invert every half period of 20 ns
  always #20 clk_sys = ~clk_sys;

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard: whole run needs about a hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      close_out;
    end
  end

  task automatic cmp_pc(input string n, input logic [12:0] e, input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // One decoder pulse; pc is looked at once it has updated
  task automatic do_op(input logic [3:0] k, input logic [12:0] a);
    @(posedge clk_sys);
    target <= a[10:0];
    vector_addr <= a;
    pc_low_offset <= a[7:0];
    reg_wdata <= a[7:0];
    reg_addr <= pcs_pkg::ADDR_PC_LOW;
    {step, jump, call, ret} <= {k == 4'h0, k == 4'h1, k == 4'h2, k == 4'h3};
    {ret_literal, ret_interrupt, int_vector} <= {k == 4'h4, k == 4'h5, k == 4'h6};
    {reg_wr, pc_low_add} <= {k == 4'h7, k == 4'h8};
    @(posedge clk_sys);
    {step, jump, call, ret, ret_literal, ret_interrupt} <= 6'h00;
    {int_vector, reg_wr, pc_low_add} <= 3'h0;
    #1;
  endtask

  // One register strobe; read data stands in the following cycle
  task automatic reg_acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  // One data request; the memory side is caught while it is driven
  task automatic data_acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    data_req <= 1'b1;
    data_we <= w;
    data_addr <= a;
    data_wdata <= d;
    #1;
    seen_addr = mem_addr;
    seen_we = mem_we;
    @(posedge clk_sys);
    data_req <= 1'b0;
    data_we <= 1'b0;
    #1;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    cmp_pc("pc", 13'h0000, pc);
    reg_acc(1'b1, pcs_pkg::ADDR_HI_LATCH, 8'h18);
    foreach (rows[i]) begin
      do_op(rows[i].kind, rows[i].arg);
      cmp_pc("pc", rows[i].exp, pc);
    end
    reg_acc(1'b0, pcs_pkg::ADDR_HI_LATCH, 8'h00);
    cmp_byte("latch", 8'h18, reg_rdata);
    reg_acc(1'b0, pcs_pkg::ADDR_PC_LOW, 8'h00);
    cmp_byte("pc low", 8'h53, reg_rdata);
    reg_acc(1'b1, pcs_pkg::ADDR_PC_HI_RO, 8'hFF);
    reg_acc(1'b0, pcs_pkg::ADDR_PC_HI_RO, 8'h00);
    cmp_byte("upper view", 8'h00, reg_rdata);
    @(posedge clk_sys);
    #1;
    cmp_byte("rdata idle", 8'h00, reg_rdata);
    cmp_pc("pc", 13'h1853, pc);
    // Ten calls wrap the eight entries; nine returns walk round again
    reg_acc(1'b1, pcs_pkg::ADDR_HI_LATCH, 8'h00);
    do_op(4'h1, 13'h0000);
    for (int i = 1; i <= 10; i++) do_op(4'h2, 13'(i * 16));
    for (int i = 10; i >= 2; i--) begin
      do_op(4'h3, 13'h0000);
      cmp_pc("pc", 13'(((i == 2) ? 9 : i - 1) * 16 + 1), pc);
    end
    // Pointer path with the bank bit set, then the bank mirror
    @(posedge clk_sys);
    indirect_bank_bit <= 1'b1;
    reg_acc(1'b1, pcs_pkg::ADDR_POINTER, 8'h20);
    data_acc(1'b1, 9'h000, 8'h3C);
    cmp_pc("mem addr", 13'h0120, {4'h0, seen_addr});
    cmp_byte("mem wdata", 8'h3C, mem_wdata);
    data_acc(1'b0, 9'h080, 8'h00);
    cmp_byte("data", 8'h3C, data_rdata);
    data_acc(1'b0, 9'h045, 8'h00);
    cmp_pc("mem addr", 13'h0045, {4'h0, seen_addr});
    cmp_byte("data", 8'h45 ^ 8'hA5, data_rdata);
    // Pointer aimed at the port itself
    @(posedge clk_sys);
    indirect_bank_bit <= 1'b0;
    reg_acc(1'b1, pcs_pkg::ADDR_POINTER, 8'h80);
    data_acc(1'b0, 9'h000, 8'h00);
    cmp_byte("self read", 8'h00, data_rdata);
    data_acc(1'b1, 9'h000, 8'h77);
    cmp_byte("self write", 8'h00, {7'h00, seen_we});
    // Reset in mid-run clears pc at once
    @(posedge clk_sys);
    reset_n <= 1'b0;
    #1;
    cmp_pc("pc", 13'h0000, pc);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_acc(1'b0, pcs_pkg::ADDR_HI_LATCH, 8'h00);
    cmp_byte("latch", 8'h00, reg_rdata);
    close_out;
  end
endmodule
`default_nettype wire
